// *** rtl/ahp_consts.svh ***
/*
 * Offsets, field positions, reset values and timing counts of the
 * parallel ADC host port controller.
 * Assumes inclusion by bare name from every design file that needs them.
 */
`ifndef AHP_CONSTS_SVH
`define AHP_CONSTS_SVH

`define AHP_OFS_CTRL 8'h00
`define AHP_OFS_CMD 8'h04
`define AHP_OFS_STATUS 8'h08
`define AHP_OFS_RDATA 8'h0C
`define AHP_OFS_IRQ_STAT 8'h10
`define AHP_OFS_IRQ_MASK 8'h14

`define AHP_CTRL_MODE 0
`define AHP_CTRL_AVHI 1
`define AHP_CTRL_RST 2
`define AHP_CMD_RD 16

`define AHP_EV_WDONE 0
`define AHP_EV_RDONE 1
`define AHP_EV_OVF 2
`define AHP_EV_REFUSED 3
`define AHP_EV_AVAIL 4
`define AHP_EV_W 5

`define AHP_CTRL_RESET 2'h0
`define AHP_IRQ_RESET 5'h00

`define AHP_SETUP_CYC 1
`define AHP_STROBE_CYC 2
`define AHP_HOLD_CYC 1
`define AHP_RST_CYC 4

`endif

// *** rtl/ahp_pkg.sv ***
/*
 * Types of the parallel ADC host port controller.
 * Assumes nothing of its surroundings.
 */
package ahp_pkg;

    typedef enum logic [3:0] {
        AHP_IDLE = 4'h1,
        AHP_SETUP = 4'h2,
        AHP_STROBE = 4'h4,
        AHP_HOLD = 4'h8
    } ahp_state_t;

    typedef struct packed {
        logic is_write;
        logic [1:0] reg_addr;
        logic [9:0] data;
    } ahp_cmd_t;

endpackage

// *** rtl/ahp_pin_seq.sv ***
/*
 * Pin sequencer: runs one read or write access on the ADC's parallel bus.
 * Assumes the device's inputs are sampled with margin by the chosen
 * setup, strobe and hold counts at the core clock rate.
 */
`include "ahp_consts.svh"

module ahp_pin_seq
    import ahp_pkg::*;
#(
    parameter int unsigned SETUP_CYC = `AHP_SETUP_CYC,
    parameter int unsigned STROBE_CYC = `AHP_STROBE_CYC,
    parameter int unsigned HOLD_CYC = `AHP_HOLD_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Request side
    input wire logic start,
    input wire ahp_cmd_t cmd,
    input wire logic strobe_mode,
    output logic busy,
    output logic done,
    output logic [11:0] rd_word,
    // Device pins
    output logic [11:0] data_out,
    output logic data_oe_n,
    input wire logic [11:0] data_in,
    output logic chip_select_low_n,
    output logic chip_select_high,
    output logic wr_strobe_n,
    output logic read_strobe_n
);

    ahp_state_t state;
    ahp_state_t next_state;
    logic [7:0] cnt;
    logic is_write;

    function automatic logic [7:0] phase_len(input ahp_state_t s);
        case (s)
            AHP_SETUP: phase_len = 8'(SETUP_CYC - 1);
            AHP_STROBE: phase_len = 8'(STROBE_CYC - 1);
            AHP_HOLD: phase_len = 8'(HOLD_CYC - 1);
            default: phase_len = 8'h00;
        endcase
    endfunction

    wire last = (cnt == 8'h00);
    wire in_access = (state != AHP_IDLE);
    wire in_strobe = (state == AHP_STROBE);

    always_comb begin
        next_state = state;
        case (state)
            AHP_IDLE: if (start) next_state = AHP_SETUP;
            AHP_SETUP: if (last) next_state = AHP_STROBE;
            AHP_STROBE: if (last) next_state = AHP_HOLD;
            AHP_HOLD: if (last) next_state = AHP_IDLE;
            default: next_state = AHP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= AHP_IDLE;
            cnt <= 8'h00;
        end else begin
            state <= next_state;
            if (state != next_state) begin
                cnt <= phase_len(next_state);
            end else if (!last) begin
                cnt <= cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            is_write <= 1'b0;
            data_out <= 12'h000;
            rd_word <= 12'h000;
            done <= 1'b0;
        end else begin
            done <= (state == AHP_HOLD) && last;
            if (start && !in_access) begin
                is_write <= cmd.is_write;
                data_out <= {cmd.reg_addr[1], cmd.reg_addr[0], cmd.data};
            end
            if (in_strobe && last && !is_write) begin
                rd_word <= data_in;
            end
        end
    end

    assign busy = in_access;
    // Both selects move together so the device never sees half a select.
    assign chip_select_low_n = !in_access;
    assign chip_select_high = in_access;
    // The bus is released outside writes so the device may drive reads.
    assign data_oe_n = !(in_access && is_write);
    // In combined mode the pin is a direction line, high meaning read.
    assign wr_strobe_n = strobe_mode ? !(in_strobe && is_write)
                                     : !(in_access && is_write);
    assign read_strobe_n = !(strobe_mode && in_strobe && !is_write);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_addr_lines: assert property (
        (start && !busy && cmd.is_write) |=>
            (data_out[11:10] == $past(cmd.reg_addr)) && !data_oe_n)
        else $error("register address not on top data lines");
    chk_wr_strobe: assert property (
        (strobe_mode && !wr_strobe_n) |->
            (chip_select_high && !chip_select_low_n && !data_oe_n))
        else $error("write strobe low outside a selected write");
    chk_rd_strobe: assert property (
        !read_strobe_n |-> (strobe_mode && data_oe_n && chip_select_high))
        else $error("read strobe low outside a selected read");
    chk_select_window: assert property (
        (start && !busy) |=> (chip_select_high && !chip_select_low_n)[*4]
            ##1 (!chip_select_high && chip_select_low_n))
        else $error("chip selects not held for whole access");
    chk_bus_release: assert property (
        !data_oe_n |-> (chip_select_high && read_strobe_n))
        else $error("bus driven outside a write access");
    chk_done_time: assert property (
        (start && !busy) |-> ##5 (done && !busy))
        else $error("access did not finish on time");

    cov_write: cover property ((start && !busy && cmd.is_write) ##5 done);
    cov_read: cover property (!read_strobe_n ##1 read_strobe_n);

endmodule

// *** rtl/ahp_host.sv ***
/*
 * Host controller for a dual-channel 12-bit ADC parallel port, with an
 * AHB-Lite register slave, sticky interrupt status and device reset.
 * Assumes a single AHB-Lite master, word accesses only, and device pins
 * that are synchronous to core_clk.
 */
// Implementation choices: the AHB-Lite register port and the register offsets.
// Functional notes
// - On register writes, lines 10 and 11 carry register address bits.
// - In strobe mode a low write strobe marks a write access.
// - In strobe mode a low read strobe requests a result word.
// - Strobe roles unknown at power-up; first access must be a write.
// - Device answers only with low select low and high select high.
`include "ahp_consts.svh"

module ahp_host
    import ahp_pkg::*;
#(
    parameter int unsigned SETUP_CYC = `AHP_SETUP_CYC,
    parameter int unsigned STROBE_CYC = `AHP_STROBE_CYC,
    parameter int unsigned HOLD_CYC = `AHP_HOLD_CYC,
    parameter int unsigned RST_CYC = `AHP_RST_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Interrupt
    output logic irq,
    // ADC pins
    output logic [11:0] data_out,
    output logic data_oe_n,
    input wire logic [11:0] data_in,
    output logic chip_select_low_n,
    output logic chip_select_high,
    output logic wr_strobe_n,
    output logic read_strobe_n,
    output logic device_reset,
    input wire logic fifo_overflow_flag,
    input wire logic result_available
);

    logic wr_q;
    logic [7:0] addr_q;
    logic strobe_mode;
    logic avail_hi;
    logic init_done;
    logic wr_pending;
    logic [3:0] rst_cnt;
    logic ovf_q;
    logic avail_q;
    logic [`AHP_EV_W-1:0] irq_stat;
    logic [`AHP_EV_W-1:0] irq_mask;
    logic [`AHP_EV_W-1:0] next_irq_stat;
    logic seq_busy;
    logic seq_done;
    logic [11:0] rd_word;
    ahp_cmd_t seq_cmd;

    // Zero wait states: every transfer completes in its first data cycle.
    wire addr_ph = hsel && htrans[1] && hready;
    wire rd_now = addr_ph && !hwrite;
    wire wr_ctrl = wr_q && (addr_q == `AHP_OFS_CTRL);
    wire wr_cmd = wr_q && (addr_q == `AHP_OFS_CMD);
    wire wr_stat = wr_q && (addr_q == `AHP_OFS_IRQ_STAT);
    wire wr_mask = wr_q && (addr_q == `AHP_OFS_IRQ_MASK);
    wire rst_active = (rst_cnt != 4'h0);
    wire rst_req = wr_ctrl && hwdata[`AHP_CTRL_RST];
    wire rst_ok = rst_req && !seq_busy && !rst_active;
    wire cmd_read = hwdata[`AHP_CMD_RD];
    // Reads before the first completed write are refused: the device's
    // strobe roles are undefined until it has been configured.
    wire cmd_allowed = !cmd_read || init_done;
    wire seq_start = wr_cmd && cmd_allowed && !seq_busy && !rst_active;
    wire refused = (wr_cmd && !seq_start) || (rst_req && !rst_ok);
    // Data-available polarity must match what software set in the device.
    wire avail_lvl = avail_hi ? result_available : !result_available;
    wire [`AHP_EV_W-1:0] events = {
        avail_lvl && !avail_q,
        refused,
        fifo_overflow_flag && !ovf_q,
        seq_done && !wr_pending,
        seq_done && wr_pending
    };
    wire [31:0] status_word = {27'h000_0000, rst_active, avail_lvl,
                               fifo_overflow_flag, init_done, seq_busy};

    assign seq_cmd.is_write = !cmd_read;
    assign seq_cmd.reg_addr = hwdata[11:10];
    assign seq_cmd.data = hwdata[9:0];
    // A new event wins over a write-one-to-clear in the same cycle.
    assign next_irq_stat = (irq_stat & ~(wr_stat ? hwdata[`AHP_EV_W-1:0]
                                                 : `AHP_IRQ_RESET)) | events;

    function automatic logic [31:0] read_mux(input logic [7:0] a);
        case (a)
            `AHP_OFS_CTRL: read_mux = {30'h0000_0000, avail_hi, strobe_mode};
            `AHP_OFS_STATUS: read_mux = status_word;
            `AHP_OFS_RDATA: read_mux = {20'h0_0000, rd_word};
            `AHP_OFS_IRQ_STAT: read_mux = {27'h000_0000, irq_stat};
            `AHP_OFS_IRQ_MASK: read_mux = {27'h000_0000, irq_mask};
            default: read_mux = 32'h0000_0000;
        endcase
    endfunction

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_q <= 1'b0;
            addr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else if (hready) begin
            wr_q <= addr_ph && hwrite;
            addr_q <= haddr[7:0];
            if (rd_now) begin
                hrdata <= read_mux(haddr[7:0]);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            {avail_hi, strobe_mode} <= `AHP_CTRL_RESET;
            irq_mask <= `AHP_IRQ_RESET;
            irq_stat <= `AHP_IRQ_RESET;
        end else begin
            if (wr_ctrl) begin
                strobe_mode <= hwdata[`AHP_CTRL_MODE];
                avail_hi <= hwdata[`AHP_CTRL_AVHI];
            end
            if (wr_mask) begin
                irq_mask <= hwdata[`AHP_EV_W-1:0];
            end
            irq_stat <= next_irq_stat;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rst_cnt <= 4'h0;
            init_done <= 1'b0;
            wr_pending <= 1'b0;
            ovf_q <= 1'b0;
            avail_q <= 1'b0;
        end else begin
            ovf_q <= fifo_overflow_flag;
            avail_q <= avail_lvl;
            if (seq_start) begin
                wr_pending <= !cmd_read;
            end
            // A device reset clears init_done, so reads are refused until the next completed write.
            if (rst_ok) begin
                rst_cnt <= 4'(RST_CYC);
                init_done <= 1'b0;
            end else begin
                if (rst_active) begin
                    rst_cnt <= rst_cnt - 4'h1;
                end
                if (seq_done && wr_pending) begin
                    init_done <= 1'b1;
                end
            end
        end
    end

    assign device_reset = rst_active;
    assign irq = |(irq_stat & irq_mask);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    ahp_pin_seq #(
        .SETUP_CYC(SETUP_CYC),
        .STROBE_CYC(STROBE_CYC),
        .HOLD_CYC(HOLD_CYC)
    ) u_seq (
        .core_clk(core_clk),
        .rst(rst),
        .start(seq_start),
        .cmd(seq_cmd),
        .strobe_mode(strobe_mode),
        .busy(seq_busy),
        .done(seq_done),
        .rd_word(rd_word),
        .data_out(data_out),
        .data_oe_n(data_oe_n),
        .data_in(data_in),
        .chip_select_low_n(chip_select_low_n),
        .chip_select_high(chip_select_high),
        .wr_strobe_n(wr_strobe_n),
        .read_strobe_n(read_strobe_n)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_read_init: assert property (
        (seq_start && !seq_cmd.is_write) |-> init_done)
        else $error("read started before device configured");
    chk_refuse_flag: assert property (
        (wr_cmd && cmd_read && !init_done) |=>
            irq_stat[`AHP_EV_REFUSED] && (!seq_busy || $past(seq_busy)))
        else $error("early read not refused");
    chk_reset_len: assert property (
        rst_ok |=> device_reset[*4] ##1 (!device_reset && !init_done))
        else $error("device reset pulse length wrong");
    chk_ovf_event: assert property (
        (fifo_overflow_flag && !ovf_q) |=> irq_stat[`AHP_EV_OVF])
        else $error("overflow rise not recorded");

    cov_first_write: cover property (seq_done && wr_pending ##1 init_done);
    cov_refused: cover property (refused ##1 irq);
    cov_reset: cover property (rst_ok ##5 !device_reset);

endmodule

// *** tb/ahp_adc_model.sv ***
/*
 * Behavioural model of the converter's parallel port, control
 * registers 0 and 1, overflow flag and data-available output.
 * Assumes the bench feeds sample, ovf_event and avail_req.
 */
module ahp_adc_model (
    // Clock
    input wire logic core_clk,
    // Host pins
    input wire logic [11:0] data_out,
    input wire logic data_oe_n,
    input wire logic chip_select_low_n,
    input wire logic chip_select_high,
    input wire logic wr_strobe_n,
    input wire logic read_strobe_n,
    input wire logic device_reset,
    // Device pins
    output logic [11:0] data_in,
    output logic fifo_overflow_flag,
    output logic result_available,
    // Bench side
    input wire logic [11:0] sample,
    input wire logic ovf_event,
    input wire logic avail_req
);
    logic [9:0] ctrl0 = 10'h000;
    logic [9:0] ctrl1 = 10'h000;
    logic known = 1'b0;
    logic [11:0] last_bus = 12'h000;
    wire sel = ~chip_select_low_n & chip_select_high;
    wire wr_acc = sel & ~wr_strobe_n;
    wire rd_pin = ctrl0[0] ? ~read_strobe_n : wr_strobe_n;
    // Strobe roles are unknown until the first write or a device reset, so reads get no data.
    wire rd_acc = sel & known & rd_pin;
    // A floating bus toggles so a stale value never reads as data.
    assign data_in = ~data_oe_n ? data_out
                   : rd_acc ? sample : ~last_bus;
    assign result_available = avail_req ~^ ctrl0[1];
    initial fifo_overflow_flag = 1'b0;
    always @(posedge core_clk) begin
        last_bus <= data_in;
        if (device_reset) begin
            ctrl0 <= 10'h000;
            ctrl1 <= 10'h000;
            known <= 1'b1;
            fifo_overflow_flag <= 1'b0;
        end else begin
            // Bit 2 of register 0 picks external references.
            if (wr_acc && data_out[11:10] == 2'b00) begin
                ctrl0 <= data_out[9:0];
            end
            if (wr_acc && data_out[11:10] == 2'b01) begin
                ctrl1 <= data_out[9:0];
            end
            if (wr_acc) known <= 1'b1;
            if (ovf_event) fifo_overflow_flag <= 1'b1;
        end
    end
endmodule

// *** tb/test_adc_host_parallel_port.sv ***
/*
 * Self-checking bench of the host port controller.
 * Assumes the design files and the device model are compiled first.
 */
`include "ahp_consts.svh"

module test_adc_host_parallel_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, seed, r, st;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [11:0] data_out, data_in, sample;
    logic data_oe_n, chip_select_low_n, chip_select_high;
    logic wr_strobe_n, read_strobe_n, device_reset;
    logic fifo_overflow_flag, result_available, ovf_event, avail_req;
    int n_fail = 0;
    int checked = 0;

    ahp_host i_dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .irq, .data_out, .data_oe_n, .data_in, .chip_select_low_n,
        .chip_select_high, .wr_strobe_n, .read_strobe_n, .device_reset,
        .fifo_overflow_flag, .result_available);
    ahp_adc_model i_dev (.core_clk, .data_out, .data_oe_n,
        .chip_select_low_n, .chip_select_high, .wr_strobe_n,
        .read_strobe_n, .device_reset, .data_in, .fifo_overflow_flag,
        .result_available, .sample, .ovf_event, .avail_req);

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("TB: %0d checks, %0d mismatches", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    // Issues one device access and waits for its done or refused bit.
    task automatic cmd(input logic rdn, input logic [1:0] ra,
                       input logic [9:0] d, output logic [31:0] s);
        logic [31:0] q;
        bus(1'b1, `AHP_OFS_CMD, {15'h0000, rdn, 4'h0, ra, d}, q);
        for (int i = 0; i < 30; i++) begin
            bus(1'b0, `AHP_OFS_IRQ_STAT, 32'h0000_0000, s);
            if ((s & 32'h0000_000b) != 0) break;
        end
        bus(1'b1, `AHP_OFS_IRQ_STAT, s, q);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        #(20000 * 25);
        n_fail++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {sample, ovf_event, avail_req} = '0;
        seed = 32'h0000_e18b;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        bus(1'b0, `AHP_OFS_CTRL, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        bus(1'b0, 8'h20, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        chk({data_oe_n, chip_select_low_n, chip_select_high}, 3'b110);
        chk(hresp, 1'b0);
        bus(1'b1, `AHP_OFS_IRQ_MASK, 32'h0000_001f, r);
        cmd(1'b1, 2'h0, 10'h000, st);
        chk(st[3], 1'b1);
        #1 chk(irq, 1'b0);
        $display("TB: reset and refusal done");
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, `AHP_OFS_CTRL, m * 3, r);
            seed = xs(seed);
            cmd(1'b0, 2'h0, {seed[7:0], m[0], m[0]}, st);
            chk(st[0], 1'b1);
            chk(i_dev.ctrl0, {seed[7:0], m[0], m[0]});
            seed = xs(seed);
            cmd(1'b0, 2'h1, seed[9:0], st);
            chk(i_dev.ctrl1, seed[9:0]);
            for (int i = 0; i < 4; i++) begin
                seed = xs(seed);
                sample <= (i == 0) ? 12'h801 : seed[11:0];
                cmd(1'b1, 2'h0, 10'h000, st);
                chk(st[1], 1'b1);
                bus(1'b0, `AHP_OFS_RDATA, 32'h0000_0000, r);
                chk(r, {20'h0_0000, sample});
            end
            bus(1'b1, `AHP_OFS_IRQ_STAT, 32'h0000_001f, r);
            avail_req <= 1'b1;
            bus(1'b0, `AHP_OFS_IRQ_STAT, 32'h0000_0000, r);
            chk(r[4], 1'b1);
            avail_req <= 1'b0;
            bus(1'b1, `AHP_OFS_IRQ_STAT, 32'h0000_001f, r);
            $display("TB: mode %0d done", m);
        end
        ovf_event <= 1'b1;
        @(posedge core_clk);
        ovf_event <= 1'b0;
        bus(1'b0, `AHP_OFS_STATUS, 32'h0000_0000, r);
        chk(r[2], 1'b1);
        chk(r[1:0], 2'b10);
        bus(1'b0, `AHP_OFS_IRQ_STAT, 32'h0000_0000, r);
        chk(r[2], 1'b1);
        #1 chk(irq, 1'b1);
        bus(1'b1, `AHP_OFS_CTRL, 32'h0000_0007, r);
        bus(1'b0, `AHP_OFS_STATUS, 32'h0000_0000, r);
        chk(r[4], 1'b1);
        // Reset pulse is four cycles; eight leave margin for its end.
        repeat (8) @(posedge core_clk);
        bus(1'b0, `AHP_OFS_STATUS, 32'h0000_0000, r);
        chk(r[2], 1'b0);
        chk(r[1], 1'b0);
        chk(i_dev.ctrl0, 10'h000);
        cmd(1'b1, 2'h0, 10'h000, st);
        chk(st[3], 1'b1);
        $display("TB: overflow and device reset done");
        final_report();
    end
endmodule
